// ### ptcr_bar_model.sv
// bar target behind the window: byte-lane memory with a chosen latency
// assumes one-cycle requests whose qualifiers stand until the acknowledge
`timescale 1ns/100ps
module ptcr_bar_model (
	input  wire        mclk_in,
	input  wire        sys_rst_in,
	input  wire        bar_req_in,
	input  wire        bar_we_in,
	input  wire [3:0]  bar_be_in,
	input  wire [31:0] bar_wdata_in,
	input  wire [3:0]  dly_in,
	output reg         bar_ack_out,
	output reg  [31:0] bar_rdata_out
);
	reg [31:0] mem;
	reg [3:0]  cnt;
	reg        busy;
	integer    i;
	// wait the latency, then complete; read data toggles except on read completions
	always @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{mem, cnt, busy, bar_ack_out} <= 38'h0;
			bar_rdata_out <= 32'h5A5A_5A5A;
		end else begin
			bar_ack_out <= 1'b0;
			bar_rdata_out <= ~bar_rdata_out;
			if (bar_req_in) begin
				busy <= 1'b1;
				cnt <= dly_in;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				bar_ack_out <= 1'b1;
				if (!bar_we_in) bar_rdata_out <= mem;
				for (i = 0; i < 4; i = i + 1) if (bar_we_in && bar_be_in[i]) mem[8*i+:8] <= bar_wdata_in[8*i+:8];
			end
		end
	end
endmodule

// ### ptcr_defines.vh
// constants for the transport register block: field positions, reset values, window sizes
// assumes inclusion by the single design file ptcr_regs.v
`ifndef PTCR_DEFINES_VH
`define PTCR_DEFINES_VH
`define PTCR_CAUSE_QUEUE_BIT      0
`define PTCR_CAUSE_CONFIG_BIT     1
`define PTCR_CAUSE_RESET          8'h00
`define PTCR_STATUS_RESET         8'h00
`define PTCR_SIZE_BYTE            3'h1
`define PTCR_SIZE_HALF            3'h2
`define PTCR_SIZE_WORD            3'h4
`define PTCR_NOTIFY_ALIGN_PLAIN   2
`define PTCR_NOTIFY_ALIGN_DATA    4
`define PTCR_DEVCFG_ALIGN         4
`define PTCR_BAR_LAST             3'h5
`endif

// ### ptcr_regs.v
// register logic of a paravirtual device's pci transport: interrupt cause byte,
// doorbell decode, device status reset and the indirect configuration-space window.
// assumes the pci function core presents decoded one-cycle strobes on mclk_in.
//
// Summary of operation
// [R1] driver never writes offered features, queue count, generation or notify slot index.
// [R2] queue size write: nonzero when packed ring, else power of two.
// [R3] driver programs all queue fields before setting the activation flag.
// [R4] after status zero, driver polls until it reads zero before reinitialising.
// [R5] driver never writes zero to activation flag; only reset deactivates.
// [R6] doorbell address is region offset plus slot index times stride.
// [R7] without notification data: region 2-byte aligned, stride zero or even power of two.
// [R8] without notification data: region length at least slot times stride plus 2.
// [R9] with notification data: stride zero or power of two multiple of four, 4-aligned.
// [R10] with notification data: region length at least slot times stride plus 4.
// [R11] cause byte: bit 0 queue, bit 1 configuration change, upper bits reserved.
// [R12] reading the cause byte returns it, clears it and drops the interrupt.
// [R13] configuration-change bit is set before its notification goes out.
// [R14] with msi-x off, queue bit is set before the queue notification.
// [R15] with msi-x off, interrupt status is the or of cause bits, gating intx.
// [R16] device-specific region offset is a multiple of four bytes.
// [R17] shared regions lie inside their bar and carry unique identifiers.
// [R18] driver writes bar index, then size 1, 2 or 4, then offset.
// [R19] window data write forwards the first size bytes into the selected bar.
// [R20] window data read fetches size bytes from the bar into low data bytes.
// [R21] driver keeps window offset a multiple of the access size.
// [R22] driver uses window data only inside regions of other capabilities.
// [R23] writing zero to device status resets the device; field reads zero after.
// [R24] cause bits are sticky; a cause arriving during the clearing read survives.
// [R25] forwarded bar read completes before the window data read finishes.
`timescale 1ns/100ps
`include "ptcr_defines.vh"

module ptcr_regs #(
	parameter [31:0] NOTIFY_REGION_OFFSET = 32'h0000_1000,
	parameter [31:0] NOTIFY_STRIDE        = 32'h0000_0004,
	parameter [31:0] NOTIFY_REGION_LENGTH = 32'h0000_1000,
	parameter [31:0] DEVCFG_OFFSET        = 32'h0000_2000,
	parameter        NOTIFY_DATA_FEATURE  = 0,
	parameter        SLOT_WIDTH           = 16,
	parameter        STATUS_RESET_CYCLES  = 4
) (
	input  wire                  mclk_in,
	input  wire                  sys_rst_in,
	input  wire                  msix_enable_in,
	input  wire                  intx_disable_in,
	input  wire                  queue_event_in,
	input  wire                  config_event_in,
	input  wire                  cause_read_in,
	input  wire                  status_write_in,
	input  wire [7:0]            status_wdata_in,
	input  wire                  bar_access_in,
	input  wire [31:0]           bar_addr_in,
	input  wire [SLOT_WIDTH-1:0] queue_slot_in,
	input  wire                  win_bar_write_in,
	input  wire [2:0]            win_bar_in,
	input  wire                  win_size_write_in,
	input  wire [2:0]            win_size_in,
	input  wire                  win_offset_write_in,
	input  wire [31:0]           win_offset_in,
	input  wire                  win_data_write_in,
	input  wire                  win_data_read_in,
	input  wire [31:0]           win_data_in,
	input  wire                  bar_ack_in,
	input  wire [31:0]           bar_rdata_in,
	output reg  [7:0]            interrupt_cause_byte_out,
	output reg                   interrupt_status_out,
	output reg                   intx_out,
	output reg                   queue_notify_out,
	output reg                   config_notify_out,
	output reg                   doorbell_hit_out,
	output reg  [7:0]            device_status_out,
	output reg                   device_reset_out,
	output reg  [31:0]           doorbell_stride_word_out,
	output reg  [31:0]           indirect_window_data_out,
	output reg                   cfg_read_done_out,
	output reg                   bar_req_out,
	output reg                   bar_we_out,
	output reg  [2:0]            bar_sel_out,
	output reg  [31:0]           bar_offset_out,
	output reg  [3:0]            bar_be_out,
	output reg  [31:0]           bar_wdata_out
);

	// alignment checks on the documented layout, evaluated at elaboration
	localparam NOTIFY_ALIGN = NOTIFY_DATA_FEATURE ? `PTCR_NOTIFY_ALIGN_DATA : `PTCR_NOTIFY_ALIGN_PLAIN;
	localparam OFFSET_OK    = (NOTIFY_REGION_OFFSET % NOTIFY_ALIGN) == 0; // [R7] [R9]
	localparam DEVCFG_OK    = (DEVCFG_OFFSET % `PTCR_DEVCFG_ALIGN) == 0;  // [R16]
	// stride must be zero or a power of two that keeps the doorbell alignment
	localparam STRIDE_OK    = (NOTIFY_STRIDE == 0) ||
	                          (((NOTIFY_STRIDE & (NOTIFY_STRIDE - 1)) == 0) &&
	                           ((NOTIFY_STRIDE % NOTIFY_ALIGN) == 0));      // [R7] [R9]
	// [R17] this block declares no shared memory region, so none can leave its bar

	reg  [7:0]  interrupt_cause_byte;
	reg  [7:0]  next_cause;
	reg  [2:0]  win_bar;
	reg  [2:0]  win_size;
	reg  [31:0] win_offset;
	reg         bar_busy;
	reg         busy_is_read;
	reg  [3:0]  rst_count;
	reg         rst_active;
	wire [47:0] slot_product;
	wire [31:0] doorbell_addr;
	wire [3:0]  size_mask;
	wire        slot_fits;

	// doorbell address of the selected slot; stride zero folds all queues together
	assign slot_product  = queue_slot_in * NOTIFY_STRIDE;                               // [R6]
	assign doorbell_addr = NOTIFY_REGION_OFFSET + slot_product[31:0];                   // [R6]
	// a doorbell that would run past the region length is never decoded
	assign slot_fits     = (slot_product[31:0] + NOTIFY_ALIGN) <= NOTIFY_REGION_LENGTH; // [R8] [R10]
	assign size_mask     = (win_size == `PTCR_SIZE_BYTE) ? 4'h1 :
	                       (win_size == `PTCR_SIZE_HALF) ? 4'h3 : 4'hF;

	// sticky cause bits; a new event wins over the clearing read
	always @* begin
		next_cause = interrupt_cause_byte;
		if (cause_read_in)
			next_cause = `PTCR_CAUSE_RESET;                                             // [R12]
		if (config_event_in)
			next_cause[`PTCR_CAUSE_CONFIG_BIT] = 1'b1;                                  // [R24] [R13]
		if (queue_event_in && !msix_enable_in)
			next_cause[`PTCR_CAUSE_QUEUE_BIT] = 1'b1;                                   // [R24] [R14]
		next_cause[7:2] = 6'h00;                                                        // [R11]
	end

	// cause register, interrupt status and notification strobes
	always @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			interrupt_cause_byte     <= `PTCR_CAUSE_RESET;
			interrupt_cause_byte_out <= `PTCR_CAUSE_RESET;
			interrupt_status_out     <= 1'b0;
			intx_out                 <= 1'b0;
			queue_notify_out         <= 1'b0;
			config_notify_out        <= 1'b0;
			doorbell_hit_out         <= 1'b0;
			doorbell_stride_word_out <= 32'h0000_0000;
		end else if (rst_active) begin
			interrupt_cause_byte     <= `PTCR_CAUSE_RESET;
			interrupt_cause_byte_out <= `PTCR_CAUSE_RESET;
			interrupt_status_out     <= 1'b0;
			intx_out                 <= 1'b0;
			queue_notify_out         <= 1'b0;
			config_notify_out        <= 1'b0;
			doorbell_hit_out         <= 1'b0;
			doorbell_stride_word_out <= NOTIFY_STRIDE;
		end else begin
			interrupt_cause_byte     <= next_cause;
			interrupt_cause_byte_out <= next_cause;                                     // read data is the pre-clear value held last cycle
			// with msi-x off, status bit follows the cause bits, registered on the same edge that sets them
			interrupt_status_out     <= !msix_enable_in && (|next_cause);               // [R15]
			intx_out                 <= !msix_enable_in && !intx_disable_in && (|next_cause); // [R15]
			// notifications are registered on the same edge as the cause bit
			config_notify_out        <= config_event_in;                                // [R13]
			queue_notify_out         <= queue_event_in;                                 // [R14]
			doorbell_hit_out         <= bar_access_in && (bar_addr_in == doorbell_addr) &&
			                            OFFSET_OK && DEVCFG_OK && STRIDE_OK && slot_fits; // [R6] [R8] [R10]
			doorbell_stride_word_out <= NOTIFY_STRIDE;                                  // [R7] [R9]
		end
	end

	// device status: zero starts a reset that holds until done, then reads zero
	always @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			device_status_out <= `PTCR_STATUS_RESET;
			device_reset_out  <= 1'b0;
			rst_active        <= 1'b0;
			rst_count         <= 4'h0;
		end else if (status_write_in && status_wdata_in == 8'h00) begin
			device_reset_out  <= 1'b1;                                                  // [R23]
			rst_active        <= 1'b1;
			rst_count         <= STATUS_RESET_CYCLES[3:0];
			device_status_out <= 8'hFF;                                                 // nonzero while reset runs
		end else if (rst_active) begin
			if (rst_count == 4'h1) begin
				rst_active        <= 1'b0;
				device_reset_out  <= 1'b0;
				device_status_out <= `PTCR_STATUS_RESET;                                // [R23]
			end
			rst_count <= rst_count - 4'h1;
		end else if (status_write_in) begin
			device_status_out <= status_wdata_in;
		end
	end

	// indirect window: captures bar, size and offset, forwards data accesses
	always @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			win_bar                  <= 3'h0;
			win_size                 <= `PTCR_SIZE_WORD;
			win_offset               <= 32'h0000_0000;
			bar_busy                 <= 1'b0;
			busy_is_read             <= 1'b0;
			bar_req_out              <= 1'b0;
			bar_we_out               <= 1'b0;
			bar_sel_out              <= 3'h0;
			bar_offset_out           <= 32'h0000_0000;
			bar_be_out               <= 4'h0;
			bar_wdata_out            <= 32'h0000_0000;
			indirect_window_data_out <= 32'h0000_0000;
			cfg_read_done_out        <= 1'b0;
		end else begin
			cfg_read_done_out <= 1'b0;
			bar_req_out       <= 1'b0;
			if (win_bar_write_in)
				win_bar <= win_bar_in;                                                  // [R18]
			if (win_size_write_in)
				win_size <= win_size_in;                                                // [R18]
			if (win_offset_write_in)
				win_offset <= win_offset_in;                                            // [R18] [R21]
			if (bar_busy) begin
				if (bar_ack_in) begin
					bar_busy <= 1'b0;
					if (busy_is_read) begin
						indirect_window_data_out <= bar_rdata_in &
						    {{8{bar_be_out[3]}}, {8{bar_be_out[2]}}, {8{bar_be_out[1]}}, {8{bar_be_out[0]}}}; // [R20]
						cfg_read_done_out        <= 1'b1;                               // [R25]
					end
				end
			end else if (win_data_write_in) begin
				indirect_window_data_out <= win_data_in;
				bar_busy       <= 1'b1;
				busy_is_read   <= 1'b0;
				bar_req_out    <= 1'b1;
				bar_we_out     <= 1'b1;
				bar_sel_out    <= win_bar;
				bar_offset_out <= win_offset;
				bar_be_out     <= size_mask;
				bar_wdata_out  <= win_data_in;                                          // [R19]
			end else if (win_data_read_in) begin
				bar_busy       <= 1'b1;
				busy_is_read   <= 1'b1;
				bar_req_out    <= 1'b1;
				bar_we_out     <= 1'b0;
				bar_sel_out    <= win_bar;
				bar_offset_out <= win_offset;
				bar_be_out     <= size_mask;                                            // [R20]
			end
		end
	end

endmodule

// ### ptcr_regs_assertions.sv
// concurrent checks on the transport register block ports
// assumes one clock domain and a four-cycle status reset
`timescale 1ns/100ps
module ptcr_regs_assertions #(
	parameter [31:0] NOTIFY_REGION_OFFSET = 32'h0000_1000,
	parameter [31:0] NOTIFY_STRIDE        = 32'h0000_0004,
	parameter        SLOT_WIDTH           = 16
) (
	input wire                  mclk_in, sys_rst_in, msix_enable_in, intx_disable_in, queue_event_in,
	input wire                  config_event_in, cause_read_in, status_write_in, bar_access_in,
	input wire                  win_data_read_in, win_data_write_in, bar_ack_in, bar_we_out,
	input wire [7:0]            status_wdata_in, interrupt_cause_byte_out, device_status_out,
	input wire [31:0]           bar_addr_in,
	input wire [SLOT_WIDTH-1:0] queue_slot_in,
	input wire                  interrupt_status_out, intx_out, config_notify_out, doorbell_hit_out,
	input wire                  device_reset_out, cfg_read_done_out, bar_req_out
);
	// doorbell address of the selected slot
	wire [31:0] slot_addr = NOTIFY_REGION_OFFSET + queue_slot_in * NOTIFY_STRIDE;
	wire        slot_hit  = bar_access_in && (bar_addr_in == slot_addr);
	wire        quiet     = !device_reset_out && !status_write_in;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence clear_read; cause_read_in && !queue_event_in && !config_event_in; endsequence
	sequence zero_write; status_write_in && status_wdata_in == 8'h00; endsequence
	sequence reset_run; device_reset_out [*4] ##1 !device_reset_out && device_status_out == 8'h00; endsequence
	reserved_zero_a: assert property (interrupt_cause_byte_out[7:2] == 6'h00) else $error("reserved cause bits set");
	cfg_cause_a: assert property (config_event_in && quiet |=> interrupt_cause_byte_out[1] && config_notify_out)
		else $error("config cause missing");
	queue_cause_a: assert property (queue_event_in && !msix_enable_in && quiet |=> interrupt_cause_byte_out[0])
		else $error("queue cause missing");
	status_or_a: assert property (!msix_enable_in && !$past(msix_enable_in) |-> interrupt_status_out == |interrupt_cause_byte_out)
		else $error("interrupt status differs from cause");
	intx_gate_a: assert property ($stable(intx_disable_in) |-> intx_out == (interrupt_status_out && !intx_disable_in))
		else $error("intx wrong");
	read_clear_a: assert property (clear_read |=> interrupt_cause_byte_out == 8'h00 && !intx_out) else $error("read kept cause");
	sticky_cause_a: assert property (cause_read_in && config_event_in && quiet |=> interrupt_cause_byte_out[1])
		else $error("cause lost in read");
	doorbell_hit_a: assert property (bar_access_in |=> doorbell_hit_out == $past(slot_hit)) else $error("doorbell decode wrong");
	status_reset_a: assert property (zero_write |=> reset_run) else $error("status reset wrong");
	window_req_a: assert property (bar_req_out |-> $past(win_data_read_in) || $past(win_data_write_in))
		else $error("bar request without window access");
	read_done_a: assert property (bar_ack_in |=> cfg_read_done_out == !$past(bar_we_out)) else $error("read completion wrong");
endmodule
bind ptcr_regs ptcr_regs_assertions #(.NOTIFY_REGION_OFFSET(NOTIFY_REGION_OFFSET), .NOTIFY_STRIDE(NOTIFY_STRIDE),
	.SLOT_WIDTH(SLOT_WIDTH)) chk_u (.*);

// ### tb_top.sv
// self-checking bench for ptcr_regs and its bar target model
// assumes default notification layout: region 0x1000, stride 4
`timescale 1ns/100ps
module tb_top;
	reg         mclk_in = 0, sys_rst_in = 1, msix_enable_in = 0, intx_disable_in = 0, queue_event_in = 0;
	reg         config_event_in = 0, cause_read_in = 0, status_write_in = 0, bar_access_in = 0, win_data_read_in = 0;
	reg         win_bar_write_in = 0, win_size_write_in = 0, win_offset_write_in = 0, win_data_write_in = 0;
	reg  [7:0]  status_wdata_in = 8'h00;
	reg  [31:0] bar_addr_in = 32'h0, win_offset_in = 32'h0, win_data_in = 32'h0;
	reg  [15:0] queue_slot_in = 16'h0;
	reg  [2:0]  win_bar_in = 3'h0, win_size_in = 3'h4;
	reg  [3:0]  dly = 4'h0;
	wire [7:0]  cause, dev_status;
	wire        int_status, intx, hit, dev_rst, done, req, we, bar_ack_in, q_ntf, cfg_ntf;
	// the bench never writes features, queue count, size, enable or slot fields
	wire [31:0] stride, wdat, boff, bar_rdata_in, bwd;
	wire [2:0]  bsel;
	wire [3:0]  be;
	integer     fail_count = 0, cmp_count = 0, cyc = 0, k;
	ptcr_regs dut_u (.mclk_in, .sys_rst_in, .msix_enable_in, .intx_disable_in, .queue_event_in, .config_event_in,
		.cause_read_in, .status_write_in, .status_wdata_in, .bar_access_in, .bar_addr_in, .queue_slot_in,
		.win_bar_write_in, .win_bar_in, .win_size_write_in, .win_size_in, .win_offset_write_in, .win_offset_in,
		.win_data_write_in, .win_data_read_in, .win_data_in, .bar_ack_in, .bar_rdata_in,
		.interrupt_cause_byte_out(cause), .interrupt_status_out(int_status), .intx_out(intx), .queue_notify_out(q_ntf),
		.config_notify_out(cfg_ntf), .doorbell_hit_out(hit), .device_status_out(dev_status), .device_reset_out(dev_rst),
		.doorbell_stride_word_out(stride), .indirect_window_data_out(wdat), .cfg_read_done_out(done),
		.bar_req_out(req), .bar_we_out(we), .bar_sel_out(bsel), .bar_offset_out(boff), .bar_be_out(be), .bar_wdata_out(bwd));
	ptcr_bar_model bar_u (.mclk_in, .sys_rst_in, .bar_req_in(req), .bar_we_in(we), .bar_be_in(be), .bar_wdata_in(bwd),
		.dly_in(dly), .bar_ack_out(bar_ack_in), .bar_rdata_out(bar_rdata_in));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// strobes set at a falling edge are dropped at the next one
	task tick;
		begin
			@(negedge mclk_in);
			if (queue_event_in) queue_event_in = 0;
			if (config_event_in) config_event_in = 0;
			if (cause_read_in) cause_read_in = 0;
			if (status_write_in) status_write_in = 0;
			if (bar_access_in) bar_access_in = 0;
			if (win_bar_write_in) win_bar_write_in = 0;
			if (win_size_write_in) win_size_write_in = 0;
			if (win_offset_write_in) win_offset_write_in = 0;
			if (win_data_write_in) win_data_write_in = 0;
			if (win_data_read_in) win_data_read_in = 0;
		end
	endtask
	task results;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	task t_status;
		begin
			chk(stride, 32'h0000_0004);
			status_write_in = 1; tick;
			chk(dev_rst, 1'b1);
			repeat (4) @(negedge mclk_in);
			chk({dev_rst, dev_status}, 9'h000);
		end
	endtask
	task t_cause;
		begin
			config_event_in = 1; tick;
			chk({cause, int_status, intx}, 10'h00B);
			chk(cfg_ntf, 1'b1);
			intx_disable_in = 1; tick;
			chk({int_status, intx}, 2'b10);
			intx_disable_in = 0; cause_read_in = 1; queue_event_in = 1; tick;
			chk(cause, 8'h01);
			chk(q_ntf, 1'b1);
			@(negedge mclk_in);
			cause_read_in = 1; tick;
			chk({cause, intx}, 9'h000);
			msix_enable_in = 1; queue_event_in = 1; tick;
			chk({cause, int_status}, 9'h000);
			msix_enable_in = 0; tick;
		end
	endtask
	// even steps hit a slot doorbell, odd steps fall between slots
	task t_door;
		begin
			for (k = 0; k < 8; k = k + 1) begin
				bar_access_in = 1; queue_slot_in = k[16:1]; bar_addr_in = 32'h0000_1000 + 2 * k; tick;
				chk(hit, !k[0]);
				@(negedge mclk_in);
			end
		end
	endtask
	task t_win(input [2:0] sz, input [3:0] xbe);
		begin
			dly = {1'b0, sz} - 4'h1;
			win_bar_write_in = 1; win_bar_in = 3'h2; tick;
			win_size_write_in = 1; win_size_in = sz; tick;
			win_offset_write_in = 1; win_offset_in = {27'h0, sz, 2'b00}; tick;
			win_data_write_in = 1; win_data_in = 32'h8C4B_27E1 ^ {29'h0, sz}; tick;
			chk({req, we, bsel, be}, {2'b11, 3'h2, xbe});
			chk(boff, {27'h0, sz, 2'b00});
			chk(bwd, win_data_in);
			for (k = 0; bar_ack_in !== 1'b1 && k < 20; k = k + 1) tick;
			tick;
			win_data_read_in = 1; tick;
			chk({req, we}, 2'b10);
			for (k = 0; done !== 1'b1 && k < 20; k = k + 1) tick;
			chk(done, 1'b1);
			chk(wdat, win_data_in & {{8{xbe[3]}}, {8{xbe[2]}}, {8{xbe[1]}}, {8{xbe[0]}}});
		end
	endtask
	initial begin
		forever #4 mclk_in = ~mclk_in;
	end
	// ceiling far above the fewer than one hundred cycles the scenarios take
	always @(posedge mclk_in) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			results;
		end
	end
	initial begin
		repeat (6) @(negedge mclk_in);
		sys_rst_in = 0;
		tick;
		t_status;
		t_cause;
		t_door;
		t_win(3'h1, 4'h1);
		t_win(3'h2, 4'h3);
		t_win(3'h4, 4'hF);
		results;
	end
endmodule
